// >>> cic_pkg.sv
// Purpose: shared constants and types of the cpu interrupt controller
// Assumes: 8-bit register port, 18 sources numbered by vector order
// Notes:   every offset, bit position and reset value lives here once
`default_nettype none
package cic_pkg;
   // -----------------------------------------------------------------
   // sizes and timing
   // -----------------------------------------------------------------
   localparam int NUM_SRC = 18;
   localparam int DETECT_CYCLES = 1; // machine cycle that takes a request
   localparam int CALL_CYCLES = 6; // machine cycles of the forced call
   localparam logic [7:0] VEC_BASE = 8'h03;
   localparam int VEC_SHIFT = 3; // vectors sit eight bytes apart

   // -----------------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_FLAGS_A = 8'h88;
   localparam logic [7:0] ADDR_FLAGS_AES = 8'h98;
   localparam logic [7:0] ADDR_FLAGS_RADIO = 8'h9b;
   localparam logic [7:0] ADDR_PRIO_LO = 8'ha9;
   localparam logic [7:0] ADDR_EN_B = 8'hb8;
   localparam logic [7:0] ADDR_PRIO_HI = 8'hb9;
   localparam logic [7:0] ADDR_FLAGS_D = 8'hc0;
   localparam logic [7:0] ADDR_FLAGS_E = 8'he8;
   localparam logic [7:0] ADDR_EN_A = 8'ha8;
   localparam logic [7:0] ADDR_EN_C = 8'h9a;

   // -----------------------------------------------------------------
   // reset values and writable masks
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_FLAGS_A = 8'h05; // detect mode bits start at 1
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] MASK_EN_A = 8'hbf;
   localparam logic [7:0] MASK_EN_BC = 8'h3f;

   // -----------------------------------------------------------------
   // source numbers
   // -----------------------------------------------------------------
   localparam int SRC_RFERR = 0;
   localparam int SRC_ADC = 1;
   localparam int SRC_URX0 = 2;
   localparam int SRC_URX1 = 3;
   localparam int SRC_AES = 4;
   localparam int SRC_ST = 5;
   localparam int SRC_P2 = 6;
   localparam int SRC_UTX0 = 7;
   localparam int SRC_DMA = 8;
   localparam int SRC_T1 = 9;
   localparam int SRC_T2 = 10;
   localparam int SRC_T3 = 11;
   localparam int SRC_T4 = 12;
   localparam int SRC_P0 = 13;
   localparam int SRC_UTX1 = 14;
   localparam int SRC_P1 = 15;
   localparam int SRC_RF = 16;
   localparam int SRC_WDT = 17;

   // -----------------------------------------------------------------
   // flag bit positions
   // -----------------------------------------------------------------
   localparam int FA_URX1 = 7;
   localparam int FA_ADC = 5;
   localparam int FA_URX0 = 3;
   localparam int FA_DET_HI = 2;
   localparam int FA_RFERR = 1;
   localparam int FA_DET_LO = 0;
   localparam int DUAL_HI = 1;
   localparam int DUAL_LO = 0;
   localparam int FD_ST = 7;
   localparam int FD_FORCE = 6;
   localparam int FD_P0 = 5;
   localparam int FD_T4 = 4;
   localparam int FD_T3 = 3;
   localparam int FD_T2 = 2;
   localparam int FD_T1 = 1;
   localparam int FD_DMA = 0;
   localparam int FE_WDT = 4;
   localparam int FE_P1 = 3;
   localparam int FE_UTX1 = 2;
   localparam int FE_UTX0 = 1;
   localparam int FE_P2 = 0;

   // -----------------------------------------------------------------
   // enable bit positions
   // -----------------------------------------------------------------
   localparam int EA_GLOBAL = 7;
   localparam int EA_ST = 5;
   localparam int EA_AES = 4;
   localparam int EA_URX1 = 3;
   localparam int EA_URX0 = 2;
   localparam int EA_ADC = 1;
   localparam int EA_RFERR = 0;
   localparam int EB_P0 = 5;
   localparam int EB_T4 = 4;
   localparam int EB_T3 = 3;
   localparam int EB_T2 = 2;
   localparam int EB_T1 = 1;
   localparam int EB_DMA = 0;
   localparam int EC_WDT = 5;
   localparam int EC_P1 = 4;
   localparam int EC_UTX1 = 3;
   localparam int EC_UTX0 = 2;
   localparam int EC_P2 = 1;
   localparam int EC_RF = 0;

   // -----------------------------------------------------------------
   // grouping table indexed by source number, polling table by poll position
   // -----------------------------------------------------------------
   localparam int GROUP_OF [NUM_SRC] =
      '{0, 1, 2, 3, 4, 5, 1, 2, 0, 1, 2, 3, 4, 5, 3, 4, 0, 5};
   localparam int POLL_ORDER [NUM_SRC] =
      '{SRC_RFERR, SRC_RF, SRC_DMA, SRC_ADC, SRC_T1, SRC_URX0, SRC_T2,
        SRC_URX1, SRC_T3, SRC_AES, SRC_T4, SRC_ST, SRC_P0, SRC_P2,
        SRC_UTX0, SRC_UTX1, SRC_P1, SRC_WDT};

   // -----------------------------------------------------------------
   // state types
   // -----------------------------------------------------------------
   typedef enum logic {CIC_IDLE, CIC_CALL} cic_state_t;

   typedef struct packed {
      logic [7:0] flags_a;
      logic [7:0] aes;
      logic [7:0] radio;
      logic [7:0] prio_lo;
      logic [7:0] prio_hi;
      logic [7:0] flags_d;
      logic [7:0] flags_e;
      logic [7:0] en_a;
      logic [7:0] en_b;
      logic [7:0] en_c;
      logic [3:0] active;
      cic_state_t st;
      logic [2:0] cnt;
      logic call;
      logic [7:0] vec;
      logic [4:0] id;
      logic [1:0] lvl;
      logic act_any;
      logic [7:0] rd_data;
   } cic_regs_t;

   localparam cic_regs_t CIC_RESET = '{
      flags_a: RST_FLAGS_A, aes: RST_ZERO, radio: RST_ZERO,
      prio_lo: RST_ZERO, prio_hi: RST_ZERO, flags_d: RST_ZERO,
      flags_e: RST_ZERO, en_a: RST_ZERO, en_b: RST_ZERO, en_c: RST_ZERO,
      active: 4'h0, st: CIC_IDLE, cnt: 3'h0, call: 1'b0, vec: 8'h00,
      id: 5'h00, lvl: 2'h0, act_any: 1'b0, rd_data: 8'h00};
endpackage : cic_pkg
`default_nettype wire

// >>> cic_arbiter.sv
// Purpose: picks the winning request by level, then by polling order
// Assumes: req already gated by flags, enables and global enable
// Notes:   purely combinational; the top registers what it uses
`default_nettype none
`timescale 1ns/1ns
module cic_arbiter
   import cic_pkg::*;
(
   input wire logic [NUM_SRC-1:0] req,
   input wire logic [5:0] prio_lo,
   input wire logic [5:0] prio_hi,
   output logic win_valid,
   output logic [4:0] win_id,
   output logic [1:0] win_level
);
   // -----------------------------------------------------------------
   // level of a source from its group's two priority bits
   // -----------------------------------------------------------------
   function automatic logic [1:0] level_of(input int id,
                                           input logic [5:0] lo,
                                           input logic [5:0] hi);
      return {hi[GROUP_OF[id]], lo[GROUP_OF[id]]};
   endfunction : level_of

   logic [1:0] best;
   logic any;
   logic found;

   // -----------------------------------------------------------------
   // highest level first, then first match in the fixed polling order
   // -----------------------------------------------------------------
   always_comb begin
      best = 2'h0;
      any = 1'b0;
      found = 1'b0;
      win_id = 5'h00;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (req[i] && (!any || level_of(i, prio_lo, prio_hi) > best)) begin
            best = level_of(i, prio_lo, prio_hi);
            any = 1'b1;
         end
      end
      // ties go by polling order, never by bit position
      for (int k = 0; k < NUM_SRC; k++) begin
         if (!found && req[POLL_ORDER[k]] &&
             level_of(POLL_ORDER[k], prio_lo, prio_hi) == best) begin
            found = 1'b1;
            win_id = 5'(POLL_ORDER[k]);
         end
      end
      win_valid = any;
      win_level = best;
   end
endmodule : cic_arbiter
`default_nettype wire

// >>> cic_top.sv
// Purpose: interrupt controller for a small cpu core, 18 sources
// Assumes: one mclk edge with ce high is one machine cycle
// Notes:   the cpu resumes the interrupted code itself after a return
//
// How it works
// - flags set on events regardless of enable
// - enabled pending request forces call next instruction
// - one detect cycle plus six call cycles
// - preempt only for strictly higher level
// - lower or equal requests stay pending meanwhile
// - return ends the highest active service level
// - some flags cleared by hardware on vectoring
// - detect mode bits reset to one, kept
// - aes event sets both aes flags
// - radio event sets both radio flags
// - force bit written one always enables source
// - group level from high and low bits
// - six groups of three sources each
// - same level ties resolved by polling order
// - polling order fixed across all eighteen sources
// - enable b holds port0, timers, dma
// - enable c holds wdt, ports, tx, radio
// - enable a holds st, aes, rx, adc, rferr
// - global enable bit gates every acknowledge
// - flags a holds rx1, adc, rx0, rferr
// - flags d holds st, port0, timers, dma
// - flags e holds wdt, port1, tx, port2
//
// The address-and-strobe port is this design's own decision.
`default_nettype none
`timescale 1ns/1ns
module cic_top
   import cic_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_r,
   input wire logic [NUM_SRC-1:0] src_event,
   input wire logic instr_boundary,
   input wire logic return_from_service,
   output logic forced_long_call_r,
   output logic [7:0] service_vector_r,
   output logic [1:0] service_level_r,
   output logic service_active_r
);
   cic_regs_t r;
   cic_regs_t n;

   logic [NUM_SRC-1:0] pend;
   logic [NUM_SRC-1:0] en;
   logic [NUM_SRC-1:0] req;
   logic win_valid;
   logic [4:0] win_id;
   logic [1:0] win_level;
   logic [1:0] cur_level;
   logic take;
   logic [7:0] set_fa;
   logic [7:0] set_fd;
   logic [7:0] set_fe;
   logic [7:0] clr_fa;
   logic [7:0] clr_fd;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // highest set bit of the active-level stack
   function automatic logic [1:0] top_level(input logic [3:0] a);
      logic [1:0] l;
      l = 2'h0;
      for (int i = 0; i < 4; i++) begin
         if (a[i]) begin
            l = 2'(i);
         end
      end
      return l;
   endfunction : top_level

   // pending view per source number; dual flags request on either bit
   function automatic logic [NUM_SRC-1:0] pend_of(input cic_regs_t s);
      logic [NUM_SRC-1:0] p;
      p = '0;
      p[SRC_RFERR] = s.flags_a[FA_RFERR];
      p[SRC_ADC] = s.flags_a[FA_ADC];
      p[SRC_URX0] = s.flags_a[FA_URX0];
      p[SRC_URX1] = s.flags_a[FA_URX1];
      p[SRC_AES] = s.aes[DUAL_HI] | s.aes[DUAL_LO];
      p[SRC_ST] = s.flags_d[FD_ST];
      p[SRC_P0] = s.flags_d[FD_P0];
      p[SRC_T4] = s.flags_d[FD_T4];
      p[SRC_T3] = s.flags_d[FD_T3];
      p[SRC_T2] = s.flags_d[FD_T2];
      p[SRC_T1] = s.flags_d[FD_T1];
      p[SRC_DMA] = s.flags_d[FD_DMA];
      p[SRC_WDT] = s.flags_e[FE_WDT];
      p[SRC_P1] = s.flags_e[FE_P1];
      p[SRC_UTX1] = s.flags_e[FE_UTX1];
      p[SRC_UTX0] = s.flags_e[FE_UTX0];
      p[SRC_P2] = s.flags_e[FE_P2];
      p[SRC_RF] = s.radio[DUAL_HI] | s.radio[DUAL_LO];
      return p;
   endfunction : pend_of

   // -----------------------------------------------------------------
   // enable and request vectors
   // -----------------------------------------------------------------
   always_comb begin
      en = '0;
      en[SRC_ST] = r.en_a[EA_ST] | r.flags_d[FD_FORCE];
      en[SRC_AES] = r.en_a[EA_AES];
      en[SRC_URX1] = r.en_a[EA_URX1];
      en[SRC_URX0] = r.en_a[EA_URX0];
      en[SRC_ADC] = r.en_a[EA_ADC];
      en[SRC_RFERR] = r.en_a[EA_RFERR];
      en[SRC_P0] = r.en_b[EB_P0];
      en[SRC_T4] = r.en_b[EB_T4];
      en[SRC_T3] = r.en_b[EB_T3];
      en[SRC_T2] = r.en_b[EB_T2];
      en[SRC_T1] = r.en_b[EB_T1];
      en[SRC_DMA] = r.en_b[EB_DMA];
      en[SRC_WDT] = r.en_c[EC_WDT];
      en[SRC_P1] = r.en_c[EC_P1];
      en[SRC_UTX1] = r.en_c[EC_UTX1];
      en[SRC_UTX0] = r.en_c[EC_UTX0];
      en[SRC_P2] = r.en_c[EC_P2];
      en[SRC_RF] = r.en_c[EC_RF];
   end

   assign pend = pend_of(r);
   // global enable off means nothing reaches the arbiter
   assign req = pend & en & {NUM_SRC{r.en_a[EA_GLOBAL]}};

   cic_arbiter u_arb (
      .req(req),
      .prio_lo(r.prio_lo[5:0]),
      .prio_hi(r.prio_hi[5:0]),
      .win_valid(win_valid),
      .win_id(win_id),
      .win_level(win_level)
   );

   // take only at an instruction boundary and only a strictly higher level
   assign cur_level = top_level(r.active);
   assign take = (r.st == CIC_IDLE) && instr_boundary && win_valid &&
                 (!(|r.active) || win_level > cur_level);

   // -----------------------------------------------------------------
   // hardware set and clear masks
   // -----------------------------------------------------------------
   always_comb begin
      set_fa = '0;
      set_fd = '0;
      set_fe = '0;
      set_fa[FA_URX1] = src_event[SRC_URX1];
      set_fa[FA_ADC] = src_event[SRC_ADC];
      set_fa[FA_URX0] = src_event[SRC_URX0];
      set_fa[FA_RFERR] = src_event[SRC_RFERR];
      set_fd[FD_ST] = src_event[SRC_ST];
      set_fd[FD_P0] = src_event[SRC_P0];
      set_fd[FD_T4] = src_event[SRC_T4];
      set_fd[FD_T3] = src_event[SRC_T3];
      set_fd[FD_T2] = src_event[SRC_T2];
      set_fd[FD_T1] = src_event[SRC_T1];
      set_fd[FD_DMA] = src_event[SRC_DMA];
      set_fe[FE_WDT] = src_event[SRC_WDT];
      set_fe[FE_P1] = src_event[SRC_P1];
      set_fe[FE_UTX1] = src_event[SRC_UTX1];
      set_fe[FE_UTX0] = src_event[SRC_UTX0];
      set_fe[FE_P2] = src_event[SRC_P2];
   end

   // flags that vectoring clears; all others wait for software
   always_comb begin
      clr_fa = '0;
      clr_fd = '0;
      if (take) begin
         clr_fa[FA_URX1] = (win_id == 5'(SRC_URX1));
         clr_fa[FA_ADC] = (win_id == 5'(SRC_ADC));
         clr_fa[FA_URX0] = (win_id == 5'(SRC_URX0));
         clr_fa[FA_RFERR] = (win_id == 5'(SRC_RFERR));
         clr_fd[FD_T1] = (win_id == 5'(SRC_T1));
         clr_fd[FD_T2] = (win_id == 5'(SRC_T2));
         clr_fd[FD_T3] = (win_id == 5'(SRC_T3));
         clr_fd[FD_T4] = (win_id == 5'(SRC_T4));
      end
   end

   // -----------------------------------------------------------------
   // next state: registers, read port, service sequencer
   // -----------------------------------------------------------------
   always_comb begin
      n = r;
      // read data stand for exactly the cycle after the strobe
      n.rd_data = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_FLAGS_A: n.rd_data = r.flags_a;
            ADDR_FLAGS_AES: n.rd_data = r.aes;
            ADDR_FLAGS_RADIO: n.rd_data = r.radio;
            ADDR_PRIO_LO: n.rd_data = r.prio_lo;
            ADDR_PRIO_HI: n.rd_data = r.prio_hi;
            ADDR_FLAGS_D: n.rd_data = r.flags_d;
            ADDR_FLAGS_E: n.rd_data = r.flags_e;
            ADDR_EN_A: n.rd_data = r.en_a;
            ADDR_EN_B: n.rd_data = r.en_b;
            ADDR_EN_C: n.rd_data = r.en_c;
            default: n.rd_data = 8'h00;
         endcase
      end
      // plain writes; detect mode bits are stored as written
      if (reg_wr) begin
         unique case (reg_addr)
            ADDR_FLAGS_A: n.flags_a = reg_wdata;
            ADDR_FLAGS_AES: n.aes = reg_wdata;
            ADDR_FLAGS_RADIO: n.radio = reg_wdata;
            ADDR_PRIO_LO: n.prio_lo = reg_wdata;
            ADDR_PRIO_HI: n.prio_hi = reg_wdata;
            ADDR_FLAGS_D: n.flags_d = reg_wdata;
            ADDR_FLAGS_E: n.flags_e = reg_wdata;
            ADDR_EN_A: n.en_a = reg_wdata & MASK_EN_A;
            ADDR_EN_B: n.en_b = reg_wdata & MASK_EN_BC;
            ADDR_EN_C: n.en_c = reg_wdata & MASK_EN_BC;
            default: n.rd_data = n.rd_data;
         endcase
      end
      // hardware set wins over any clear in the same cycle
      n.flags_a = (n.flags_a & ~clr_fa) | set_fa;
      n.flags_d = (n.flags_d & ~clr_fd) | set_fd;
      n.flags_e = n.flags_e | set_fe;
      if (src_event[SRC_AES]) begin
         n.aes[DUAL_HI] = 1'b1;
         n.aes[DUAL_LO] = 1'b1;
      end
      if (src_event[SRC_RF]) begin
         n.radio[DUAL_HI] = 1'b1;
         n.radio[DUAL_LO] = 1'b1;
      end
      // return drops the innermost service level first
      if (return_from_service && (|r.active)) begin
         n.active[cur_level] = 1'b0;
      end
      unique case (r.st)
         CIC_IDLE: begin
            if (take) begin
               n.st = CIC_CALL;
               n.call = 1'b1;
               n.cnt = 3'(CALL_CYCLES - 1);
               n.id = win_id;
               n.lvl = win_level;
               n.vec = VEC_BASE + 8'({3'h0, win_id} << VEC_SHIFT);
            end
         end
         CIC_CALL: begin
            if (r.cnt == 3'h0) begin
               n.st = CIC_IDLE;
               n.call = 1'b0;
               n.active[r.lvl] = 1'b1;
            end else begin
               n.cnt = r.cnt - 3'h1;
            end
         end
      endcase
      n.act_any = |n.active;
   end

   // -----------------------------------------------------------------
   // state register; ce low freezes everything but reset
   // -----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         r <= CIC_RESET;
      end else if (ce) begin
         r <= n;
      end
   end

   assign reg_rdata_r = r.rd_data;
   assign forced_long_call_r = r.call;
   assign service_vector_r = r.vec;
   assign service_level_r = r.lvl;
   assign service_active_r = r.act_any;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst || !ce);

   AST_FLAG_SET: assert property (
      (|src_event) |=> ((pend & $past(src_event)) == $past(src_event)))
      else $error("event did not leave its flag pending");
   AST_TAKE_VECTOR: assert property (
      take |=> forced_long_call_r &&
         service_vector_r == VEC_BASE + 8'({3'h0, $past(win_id)} << 3))
      else $error("taken request not turned into a call to its vector");
   AST_CALL_LENGTH: assert property (
      $rose(forced_long_call_r) |->
         forced_long_call_r [*6] ##1 !forced_long_call_r)
      else $error("forced call did not last six cycles");
   AST_NO_PREEMPT: assert property (
      $rose(forced_long_call_r) |->
         (!$past(service_active_r) ||
          $past(win_level) > $past(cur_level)))
      else $error("call started without a strictly higher level");
   AST_HOLD_PENDING: assert property (
      (r.st == CIC_IDLE && (|r.active) && win_valid &&
       win_level <= cur_level) |=> !forced_long_call_r)
      else $error("equal or lower request preempted a service");
   AST_RETURN_POP: assert property (
      (return_from_service && (|r.active) && r.st == CIC_IDLE) |=>
         $countones(r.active) == $countones($past(r.active)) - 1)
      else $error("return did not end one service level");
   AST_HW_CLEAR: assert property (
      (take && win_id == 5'(SRC_T1) && !src_event[SRC_T1] &&
       !(reg_wr && reg_addr == ADDR_FLAGS_D)) |=> !r.flags_d[FD_T1])
      else $error("timer a flag not cleared on vectoring");
   AST_DETECT_KEEP: assert property (
      !(reg_wr && reg_addr == ADDR_FLAGS_A) |=>
         $stable(r.flags_a[FA_DET_HI]) && $stable(r.flags_a[FA_DET_LO]))
      else $error("detect mode bits changed without a write");
   AST_AES_BOTH: assert property (
      src_event[SRC_AES] |=> r.aes[1:0] == 2'h3)
      else $error("aes event did not set both flags");
   AST_RADIO_BOTH: assert property (
      src_event[SRC_RF] |=> r.radio[1:0] == 2'h3)
      else $error("radio event did not set both flags");
   AST_GLOBAL_GATE: assert property (
      $rose(forced_long_call_r) |-> $past(r.en_a[EA_GLOBAL]))
      else $error("call taken with global enable off");
   AST_EN_B_ZERO: assert property (
      (reg_rd && reg_addr == ADDR_EN_B) |=> reg_rdata_r[7:6] == 2'h0)
      else $error("unused enable bits read back nonzero");

   COV_TAKE: cover property (take ##1 forced_long_call_r [*6]);
   COV_NESTED: cover property ($rose(forced_long_call_r) &&
                               service_active_r);
   COV_RETURN: cover property (return_from_service && service_active_r);
   COV_AES: cover property (src_event[SRC_AES] ##1 r.aes[1:0] == 2'h3);
endmodule : cic_top
`default_nettype wire

// >>> cic_cpu_model.sv
// Purpose: cpu sequencer model, boundary and return pulses
// Assumes: a routine runs three cycles, then returns
// Notes: never test-clears a flag, software stays simple
`timescale 1ns/1ns
`default_nettype none
module cic_cpu_model (
   input wire logic mclk,
   input wire logic srst,
   input wire logic service_active_r,
   input wire logic forced_long_call_r,
   output logic instr_boundary,
   output logic return_from_service
);
   logic [1:0] cnt_r;
   // ------------------------------
   // short routine, then return
   // ------------------------------
   // no return while a forced call runs: the preempting routine ends first
   always_ff @(posedge mclk) begin
      if (srst || !service_active_r || forced_long_call_r ||
          return_from_service) begin
         cnt_r <= 2'h0;
         return_from_service <= 1'b0;
      end else begin
         cnt_r <= cnt_r + 2'h1;
         return_from_service <= (cnt_r == 2'h2);
      end
   end
   // every cycle may take a request: fastest case
   assign instr_boundary = ~srst;
endmodule : cic_cpu_model
`default_nettype wire

// >>> cic_top_test.sv
// Purpose: self-checking bench of the interrupt controller
// Assumes: cpu model returns soon after each service
// Notes: only hw-cleared sources fire once enabled, else retake
`timescale 1ns/1ns
`default_nettype none
module cic_top_test
   import cic_pkg::*;
;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
   logic reg_wr = 1'b0, reg_rd = 1'b0, rd_p = 1'b0, fl_p = 1'b0;
   logic [NUM_SRC-1:0] src_event = '0;
   logic [7:0] reg_rdata_r, service_vector_r;
   logic [1:0] service_level_r;
   logic forced_long_call_r, service_active_r, instr_boundary;
   logic return_from_service;
   logic [7:0] rq[$], vq[$];
   logic [1:0] lq[$];
   int error_cnt = 0, check_count = 0, n;
   localparam int HWCLR [8] = '{0, 1, 2, 3, 9, 10, 11, 12};
   always #2 mclk = ~mclk;
   cic_top i_cic_top (.mclk(mclk), .srst(srst), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .src_event(src_event),
      .instr_boundary(instr_boundary),
      .return_from_service(return_from_service),
      .forced_long_call_r(forced_long_call_r),
      .service_vector_r(service_vector_r),
      .service_level_r(service_level_r),
      .service_active_r(service_active_r));
   cic_cpu_model i_cic_cpu_model (.mclk(mclk), .srst(srst),
      .service_active_r(service_active_r), .instr_boundary(instr_boundary),
      .forced_long_call_r(forced_long_call_r),
      .return_from_service(return_from_service));
   // ------------------------------
   // compare and verdict
   // ------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic end_of_test();
      if (error_cnt == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test
   // ------------------------------
   // register port and event drivers
   // ------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rq.push_back(e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
   endtask : rd
   // note the vector and level that the next call must show
   task automatic expect_call(input logic [7:0] v, input logic [1:0] l);
      vq.push_back(v);
      lq.push_back(l);
   endtask : expect_call
   // pulse events, leave room for one or two full services
   task automatic fire(input logic [NUM_SRC-1:0] m);
      @(posedge mclk);
      src_event <= m;
      @(posedge mclk);
      src_event <= '0;
      repeat (30) @(posedge mclk);
   endtask : fire
   // ------------------------------
   // output watcher: oldest note per result
   // ------------------------------
   always @(posedge mclk) begin
      rd_p <= reg_rd;
      fl_p <= forced_long_call_r;
      if (rd_p) check(reg_rdata_r, rq.pop_front());
      if (forced_long_call_r && !fl_p) begin
         check(service_vector_r, vq.pop_front());
         check(8'(service_level_r), 8'(lq.pop_front()));
      end
   end
   // ------------------------------
   // main sequence and watchdog
   // ------------------------------
   initial begin
      n = $urandom(32'h0826);
      repeat (6) @(posedge mclk);
      srst <= 1'b0;
      rd(ADDR_FLAGS_A, RST_FLAGS_A);
      rd(8'h00, 8'h00);
      // a frozen block must ignore an event
      @(posedge mclk);
      ce <= 1'b0;
      src_event <= 18'h1 << SRC_P2;
      @(posedge mclk);
      ce <= 1'b1;
      src_event <= '0;
      rd(ADDR_FLAGS_E, 8'h00);
      wr(ADDR_EN_B, 8'hff);
      rd(ADDR_EN_B, MASK_EN_BC);
      // global enable still off: flags set, nothing is taken
      fire((18'h1 << SRC_T1) | (18'h1 << SRC_AES) | (18'h1 << SRC_RF));
      rd(ADDR_FLAGS_D, 8'h02);
      rd(ADDR_FLAGS_AES, 8'h03);
      rd(ADDR_FLAGS_RADIO, 8'h03);
      // plain writes clear them, never a test-and-clear
      wr(ADDR_FLAGS_AES, 8'h00);
      wr(ADDR_FLAGS_RADIO, 8'h00);
      expect_call(8'h4b, 2'h0);
      wr(ADDR_EN_A, 8'hbf);
      repeat (20) @(posedge mclk);
      rd(ADDR_FLAGS_D, 8'h00);
      wr(ADDR_EN_C, 8'hff);
      rd(ADDR_EN_C, MASK_EN_BC);
      expect_call(8'h03, 2'h0);
      expect_call(8'h0b, 2'h0);
      fire(18'h3);
      wr(ADDR_PRIO_HI, 8'h02);
      wr(ADDR_PRIO_LO, 8'h02);
      expect_call(8'h0b, 2'h3);
      expect_call(8'h03, 2'h0);
      fire(18'h3);
      // level three adc arrives during the rferr call and nests
      expect_call(8'h03, 2'h0);
      expect_call(8'h0b, 2'h3);
      @(posedge mclk);
      src_event <= 18'h1 << SRC_RFERR;
      @(posedge mclk);
      src_event <= '0;
      fire(18'h1 << SRC_ADC);
      repeat (8) begin
         n = HWCLR[$urandom % 8];
         expect_call(VEC_BASE + 8'(n * 8),
                     (GROUP_OF[n] == 1) ? 2'h3 : 2'h0);
         fire(18'h1 << n);
      end
      // every noted call must have happened
      check(8'(vq.size()), 8'h00);
      end_of_test();
   end
   initial begin
      #(4 * 2000);
      error_cnt++;
      end_of_test();
   end
endmodule : cic_top_test
`default_nettype wire
